// *** pie_top.sv ***
// Peripheral interrupt enable and priority block with AXI4-Lite register access
`include "pie_defs.svh"
`default_nettype none
module pie_top #(
   parameter bit SMALL_PKG = 1'b0
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Peripheral flag levels
   input wire logic [7:0] flag_a,
   input wire logic [7:0] flag_b,
   input wire logic [7:0] flag_can,
   // Requests to the core
   output logic high_req,
   output logic low_req,
   // Block interrupt
   output logic irq
);
   localparam pie_pkg::pie_bank_t IMPL_A = SMALL_PKG ? `PIE_IMPL_A_SMALL : `PIE_IMPL_A;
   localparam pie_pkg::pie_bank_t IMPL_B = SMALL_PKG ? `PIE_IMPL_B_SMALL : `PIE_IMPL_B;
   localparam pie_pkg::pie_bank_t IMPL_CAN = `PIE_IMPL_CAN;
   localparam pie_pkg::pie_bank_t RST_CTRL = `PIE_RST_CTRL;

   // Register index from a byte address; unaligned or unknown gives none
   function automatic pie_pkg::pie_reg_t decode(input logic [7:0] a);
      case (a)
         `PIE_OFF_EN_A: decode = pie_pkg::PIE_REG_EN_A;
         `PIE_OFF_EN_B: decode = pie_pkg::PIE_REG_EN_B;
         `PIE_OFF_EN_CAN: decode = pie_pkg::PIE_REG_EN_CAN;
         `PIE_OFF_PR_A: decode = pie_pkg::PIE_REG_PR_A;
         `PIE_OFF_PR_B: decode = pie_pkg::PIE_REG_PR_B;
         `PIE_OFF_PR_CAN: decode = pie_pkg::PIE_REG_PR_CAN;
         `PIE_OFF_CTRL: decode = pie_pkg::PIE_REG_CTRL;
         `PIE_OFF_FLAGS: decode = pie_pkg::PIE_REG_FLAGS;
         `PIE_OFF_STATUS: decode = pie_pkg::PIE_REG_STATUS;
         `PIE_OFF_CLEAR: decode = pie_pkg::PIE_REG_CLEAR;
         `PIE_OFF_IRQ_EN: decode = pie_pkg::PIE_REG_IRQ_EN;
         default: decode = pie_pkg::PIE_REG_NONE;
      endcase
   endfunction : decode

   pie_pkg::pie_bank_t en_a;
   pie_pkg::pie_bank_t en_b;
   pie_pkg::pie_bank_t en_can;
   pie_pkg::pie_bank_t pr_a;
   pie_pkg::pie_bank_t pr_b;
   pie_pkg::pie_bank_t pr_can;
   logic prio_on;
   logic group_en;
   pie_pkg::pie_evt_t status;
   pie_pkg::pie_evt_t irq_en;
   pie_pkg::pie_evt_t evt_set;
   pie_pkg::pie_evt_t evt_clr;

   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   pie_pkg::pie_reg_t wr_reg;
   logic wr_low;
   logic ar_fire;
   pie_pkg::pie_reg_t rd_reg;
   logic [31:0] next_rdata;
   logic next_rresp_err;

   // Write side
   assign awready = ce & ~aw_held;
   assign wready = ce & ~w_held;
   assign wr_fire = ce & aw_held & w_held & ~bvalid;
   assign wr_reg = decode(aw_addr_q);
   // Only byte lane 0 carries register bits; other lanes are ignored
   assign wr_low = wr_fire & wstrb_q[0];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (ce) begin
         if (awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w_held <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (ce) begin
         if (wvalid && !w_held) begin
            w_held <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid <= 1'b0;
         bresp <= `PIE_RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (wr_reg == pie_pkg::PIE_REG_NONE) ? `PIE_RESP_SLVERR : `PIE_RESP_OKAY;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Enable registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_a <= `PIE_RST_EN_A & IMPL_A;
         en_b <= `PIE_RST_EN_B & IMPL_B;
         en_can <= `PIE_RST_EN_CAN & IMPL_CAN;
      end else if (wr_low) begin
         case (wr_reg)
            pie_pkg::PIE_REG_EN_A: en_a <= wdata_q[7:0] & IMPL_A;
            pie_pkg::PIE_REG_EN_B: en_b <= wdata_q[7:0] & IMPL_B;
            pie_pkg::PIE_REG_EN_CAN: en_can <= wdata_q[7:0] & IMPL_CAN;
            default: en_a <= en_a;
         endcase
      end
   end

   // Priority registers share the enable layouts
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pr_a <= `PIE_RST_PRIO & IMPL_A;
         pr_b <= `PIE_RST_PRIO & IMPL_B;
         pr_can <= `PIE_RST_PRIO & IMPL_CAN;
      end else if (wr_low) begin
         case (wr_reg)
            pie_pkg::PIE_REG_PR_A: pr_a <= wdata_q[7:0] & IMPL_A;
            pie_pkg::PIE_REG_PR_B: pr_b <= wdata_q[7:0] & IMPL_B;
            pie_pkg::PIE_REG_PR_CAN: pr_can <= wdata_q[7:0] & IMPL_CAN;
            default: pr_a <= pr_a;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prio_on <= RST_CTRL[`PIE_CTRL_PRIO_ON_BIT];
         group_en <= RST_CTRL[`PIE_CTRL_GROUP_EN_BIT];
      end else if (wr_low && wr_reg == pie_pkg::PIE_REG_CTRL) begin
         prio_on <= wdata_q[`PIE_CTRL_PRIO_ON_BIT];
         group_en <= wdata_q[`PIE_CTRL_GROUP_EN_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_en <= 2'h0;
      end else if (wr_low && wr_reg == pie_pkg::PIE_REG_IRQ_EN) begin
         irq_en <= wdata_q[1:0];
      end
   end

   // Routing
   pie_route_if rt ();

   assign rt.flag[0] = flag_a & IMPL_A;
   assign rt.flag[1] = flag_b & IMPL_B;
   assign rt.flag[2] = flag_can & IMPL_CAN;
   assign rt.en[0] = en_a;
   assign rt.en[1] = en_b;
   assign rt.en[2] = en_can;
   assign rt.prio[0] = pr_a;
   assign rt.prio[1] = pr_b;
   assign rt.prio[2] = pr_can;
   assign rt.prio_on = prio_on;
   assign rt.group_en = group_en;

   pie_route u_route (
      .rt(rt.router)
   );

   // Registered so the core sees glitch-free levels, one cycle behind the flags
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         high_req <= 1'b0;
         low_req <= 1'b0;
      end else if (ce) begin
         high_req <= rt.high_req;
         low_req <= rt.low_req;
      end
   end

   // Sticky events on each rising request; a set in the clear cycle wins
   assign evt_set[`PIE_EVT_HIGH_BIT] = rt.high_req & ~high_req;
   assign evt_set[`PIE_EVT_LOW_BIT] = rt.low_req & ~low_req;
   assign evt_clr = (wr_low && wr_reg == pie_pkg::PIE_REG_CLEAR) ? wdata_q[1:0] : 2'h0;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= 2'h0;
      end else if (ce) begin
         status <= (status & ~evt_clr) | evt_set;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(((status & ~evt_clr) | evt_set) & irq_en);
      end
   end

   // Read side
   assign arready = ce & ~rvalid;
   assign ar_fire = arvalid & arready;
   assign rd_reg = decode(araddr);

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp_err = 1'b0;
      case (rd_reg)
         pie_pkg::PIE_REG_EN_A: next_rdata[7:0] = en_a;
         pie_pkg::PIE_REG_EN_B: next_rdata[7:0] = en_b;
         pie_pkg::PIE_REG_EN_CAN: next_rdata[7:0] = en_can;
         pie_pkg::PIE_REG_PR_A: next_rdata[7:0] = pr_a;
         pie_pkg::PIE_REG_PR_B: next_rdata[7:0] = pr_b;
         pie_pkg::PIE_REG_PR_CAN: next_rdata[7:0] = pr_can;
         pie_pkg::PIE_REG_CTRL: begin
            next_rdata[`PIE_CTRL_PRIO_ON_BIT] = prio_on;
            next_rdata[`PIE_CTRL_GROUP_EN_BIT] = group_en;
         end
         pie_pkg::PIE_REG_FLAGS: next_rdata[23:0] = {rt.flag[2], rt.flag[1], rt.flag[0]};
         pie_pkg::PIE_REG_STATUS: next_rdata[1:0] = status;
         pie_pkg::PIE_REG_CLEAR: next_rdata = 32'h0000_0000;
         pie_pkg::PIE_REG_IRQ_EN: next_rdata[1:0] = irq_en;
         default: next_rresp_err = 1'b1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `PIE_RESP_OKAY;
      end else if (ce) begin
         if (ar_fire) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp_err ? `PIE_RESP_SLVERR : `PIE_RESP_OKAY;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule : pie_top
`default_nettype wire

// *** pie_defs.svh ***
// Offsets, field positions and reset values of the peripheral interrupt mask block
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH

`define PIE_OFF_EN_A 8'h00
`define PIE_OFF_EN_B 8'h04
`define PIE_OFF_EN_CAN 8'h08
`define PIE_OFF_PR_A 8'h0C
`define PIE_OFF_PR_B 8'h10
`define PIE_OFF_PR_CAN 8'h14
`define PIE_OFF_CTRL 8'h18
`define PIE_OFF_FLAGS 8'h1C
`define PIE_OFF_STATUS 8'h20
`define PIE_OFF_CLEAR 8'h24
`define PIE_OFF_IRQ_EN 8'h28

`define PIE_IMPL_A 8'hFF
`define PIE_IMPL_A_SMALL 8'h7F
`define PIE_IMPL_B 8'h5F
`define PIE_IMPL_B_SMALL 8'h1E
`define PIE_IMPL_CAN 8'hFF

`define PIE_RST_EN_A 8'h00
`define PIE_RST_EN_B 8'h00
`define PIE_RST_EN_CAN 8'hFF
`define PIE_RST_PRIO 8'hFF
`define PIE_RST_CTRL 8'h00

`define PIE_CTRL_PRIO_ON_BIT 7
`define PIE_CTRL_GROUP_EN_BIT 6
`define PIE_EVT_HIGH_BIT 0
`define PIE_EVT_LOW_BIT 1

`define PIE_RESP_OKAY 2'h0
`define PIE_RESP_SLVERR 2'h2

`endif

// *** pie_pkg.sv ***
// Types shared by the peripheral interrupt mask block
`default_nettype none
package pie_pkg;
   typedef logic [7:0] pie_bank_t;
   typedef logic [1:0] pie_evt_t;
   typedef enum logic [3:0] {
      PIE_REG_EN_A = 4'h0,
      PIE_REG_EN_B = 4'h1,
      PIE_REG_EN_CAN = 4'h2,
      PIE_REG_PR_A = 4'h3,
      PIE_REG_PR_B = 4'h4,
      PIE_REG_PR_CAN = 4'h5,
      PIE_REG_CTRL = 4'h6,
      PIE_REG_FLAGS = 4'h7,
      PIE_REG_STATUS = 4'h8,
      PIE_REG_CLEAR = 4'h9,
      PIE_REG_IRQ_EN = 4'hA,
      PIE_REG_NONE = 4'hF
   } pie_reg_t;
endpackage : pie_pkg
`default_nettype wire

// *** pie_route_if.sv ***
// Carrier between the register block and the request router
`default_nettype none
interface pie_route_if;
   pie_pkg::pie_bank_t flag [3];
   pie_pkg::pie_bank_t en [3];
   pie_pkg::pie_bank_t prio [3];
   logic prio_on;
   logic group_en;
   logic high_req;
   logic low_req;
   modport regs (output flag, en, prio, prio_on, group_en, input high_req, low_req);
   modport router (input flag, en, prio, prio_on, group_en, output high_req, low_req);
endinterface : pie_route_if
`default_nettype wire

// *** pie_route.sv ***
// Request router: masks source flags and sorts them into high and low requests
`default_nettype none
module pie_route (
   pie_route_if.router rt
);
   // Any flag both enabled and selected by the given level mask
   function automatic logic bank_req(input pie_pkg::pie_bank_t f, input pie_pkg::pie_bank_t e,
                                     input pie_pkg::pie_bank_t sel);
      bank_req = |(f & e & sel);
   endfunction : bank_req

   logic any_hi;
   logic any_lo;
   logic any_all;

   always_comb begin
      any_hi = 1'b0;
      any_lo = 1'b0;
      any_all = 1'b0;
      for (int i = 0; i < 3; i++) begin
         any_hi = any_hi | bank_req(rt.flag[i], rt.en[i], rt.prio[i]);
         any_lo = any_lo | bank_req(rt.flag[i], rt.en[i], ~rt.prio[i]);
         any_all = any_all | bank_req(rt.flag[i], rt.en[i], 8'hFF);
      end
   end

   // Single-level mode uses the high request line alone and ignores priority bits
   assign rt.high_req = rt.prio_on ? any_hi : (rt.group_en & any_all);
   assign rt.low_req = rt.prio_on & any_lo;
endmodule : pie_route
`default_nettype wire

// *** pie_top_properties.sv ***
// Port-level checks for the peripheral interrupt mask block
`include "pie_defs.svh"
`default_nettype none
module pie_top_properties (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Flags and requests
   input wire logic [7:0] flag_a,
   input wire logic [7:0] flag_b,
   input wire logic [7:0] flag_can,
   input wire logic high_req,
   input wire logic low_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic any_flag;
   assign any_flag = |{flag_a, flag_b, flag_can};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_both_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_resp_up;
      ##2 bvalid;
   endsequence
   a_write_resp: assert property (s_both_taken |-> s_resp_up)
      else $error("write response late");
   a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_bresp_code: assert property (bvalid |-> bresp == `PIE_RESP_OKAY || bresp == `PIE_RESP_SLVERR)
      else $error("bad write response code");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_ar_blocked: assert property (rvalid |-> !arready)
      else $error("address taken while data pending");
   a_ce_freeze: assert property (!ce |-> !awready && !wready && !arready)
      else $error("ready while clock enable low");
   a_quiet_req: assert property (ce && !any_flag |=> !high_req && !low_req)
      else $error("request without flag");
   a_low_cause: assert property (low_req && $past(ce) |-> $past(any_flag))
      else $error("low request without flag");
endmodule : pie_top_properties
bind pie_top pie_top_properties u_props (.clk(clk), .rst_b(rst_b), .ce(ce), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
   .rdata(rdata), .flag_a(flag_a), .flag_b(flag_b), .flag_can(flag_can),
   .high_req(high_req), .low_req(low_req));
`default_nettype wire

// *** pie_src_model.sv ***
// Peripheral flag source model feeding the mask block
`default_nettype none
module pie_src_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Raised conditions, CAN bank on top
   input wire logic [23:0] cond,
   // Flag levels
   output logic [7:0] flag_a,
   output logic [7:0] flag_b,
   output logic [7:0] flag_can
);
   timeunit 1ns;
   timeprecision 1ns;
   // Flags follow the condition alone, so software may poll them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {flag_can, flag_b, flag_a} <= 24'h000000;
      end else begin
         {flag_can, flag_b, flag_a} <= cond;
      end
   end
endmodule : pie_src_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the peripheral interrupt mask block
`include "pie_defs.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, high_req, low_req, irq;
   logic [7:0] awaddr, araddr, flag_a, flag_b, flag_can;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [23:0] cond;
   logic awready_s, wready_s, bvalid_s, arready_s, rvalid_s, high_req_s, low_req_s, irq_s;
   logic [31:0] rdata_s, rd_small;
   logic [1:0] bresp_s, rresp_s;
   int failures, n_checks;
   logic [7:0] offs [6] = '{`PIE_OFF_EN_A, `PIE_OFF_EN_B, `PIE_OFF_EN_CAN, `PIE_OFF_PR_A,
      `PIE_OFF_PR_B, `PIE_OFF_PR_CAN};
   logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h5F, 8'hFF};
   logic [7:0] impl [6] = '{8'hFF, 8'h5F, 8'hFF, 8'hFF, 8'h5F, 8'hFF};
   // Smaller package drops parallel port, comparator and enhanced capcmp bits
   logic [7:0] rst_s [6] = '{8'h00, 8'h00, 8'hFF, 8'h7F, 8'h1E, 8'hFF};
   logic [7:0] impl_s [6] = '{8'h7F, 8'h1E, 8'hFF, 8'h7F, 8'h1E, 8'hFF};
   pie_top uut (.clk(clk), .rst_b(rst_b), .ce(ce), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .flag_a(flag_a), .flag_b(flag_b), .flag_can(flag_can), .high_req(high_req),
      .low_req(low_req), .irq(irq));
   // Follows the same bus as uut; its handshake timing is identical
   pie_top #(.SMALL_PKG(1'b1)) uut_small (.clk(clk), .rst_b(rst_b), .ce(ce),
      .awvalid(awvalid), .awready(awready_s), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready_s), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid_s), .bready(bready),
      .bresp(bresp_s), .arvalid(arvalid), .arready(arready_s), .araddr(araddr),
      .rvalid(rvalid_s), .rready(rready), .rdata(rdata_s), .rresp(rresp_s), .flag_a(flag_a),
      .flag_b(flag_b), .flag_can(flag_can), .high_req(high_req_s), .low_req(low_req_s),
      .irq(irq_s));
   pie_src_model src (.clk(clk), .rst_b(rst_b), .cond(cond), .flag_a(flag_a),
      .flag_b(flag_b), .flag_can(flag_can));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      resp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rd_val = rdata;
      rd_small = rdata_s;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd
   // Flags lag the condition one edge and the request one more; look once settled
   task automatic req_is(input logic h, input logic l);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({30'h0, high_req, low_req}, {30'h0, h, l}, "request");
      @(posedge clk);
   endtask : req_is
   task automatic report_and_stop;
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      report_and_stop;
   end
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      ce = 1'b1;
      {awaddr, araddr, wdata, cond} = 72'h0;
      wstrb = 4'hF;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         rd(offs[i]);
         chk(rd_val, {24'h0, rst_v[i]}, "reset value");
         chk(rd_small, {24'h0, rst_s[i]}, "small reset value");
      end
      cond <= 24'h000001;
      req_is(1'b0, 1'b0);
      wr(`PIE_OFF_EN_A, 32'h1);
      req_is(1'b0, 1'b0);
      wr(`PIE_OFF_CTRL, 32'h40);
      req_is(1'b1, 1'b0);
      wr(`PIE_OFF_CTRL, 32'h80);
      req_is(1'b1, 1'b0);
      wr(`PIE_OFF_PR_A, 32'hFE);
      req_is(1'b0, 1'b1);
      rd(`PIE_OFF_FLAGS);
      chk(rd_val, 32'h1, "flags");
      rd(`PIE_OFF_STATUS);
      chk(rd_val, 32'h3, "status");
      chk({31'h0, irq}, 32'h0, "masked irq");
      wr(`PIE_OFF_IRQ_EN, 32'h2);
      chk({31'h0, irq}, 32'h1, "irq");
      wr(`PIE_OFF_CLEAR, 32'h3);
      chk({31'h0, irq}, 32'h0, "cleared irq");
      wr(`PIE_OFF_CTRL, 32'h40);
      req_is(1'b1, 1'b0);
      wr(`PIE_OFF_EN_A, 32'h0);
      req_is(1'b0, 1'b0);
      cond <= 24'h800000;
      req_is(1'b1, 1'b0);
      cond <= 24'h0;
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      // Flags dropped while frozen; the request must hold its old level
      chk({31'h0, high_req}, 32'h1, "frozen request");
      ce <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(offs[i], 32'hFFFFFFFF);
         rd(offs[i]);
         chk(rd_val, {24'h0, impl[i]}, "ones");
         chk(rd_small, {24'h0, impl_s[i]}, "small ones");
         wr(offs[i], 32'h0);
         rd(offs[i]);
         chk(rd_val, 32'h0, "zeros");
      end
      wr(8'h3C, 32'hFF);
      chk({30'h0, resp}, {30'h0, `PIE_RESP_SLVERR}, "unmapped write");
      rd(8'h3C);
      chk({rd_val[29:0], resp}, {30'h0, `PIE_RESP_SLVERR}, "unmapped read");
      report_and_stop;
   end
endmodule : testbench
`default_nettype wire
